// [testbench/tb_top.sv]
// Self-checking bench for the vectored interrupt priority unit
`timescale 1ns/10ps
module tb_top;
  import vip_pkg::*;
  localparam int NS = 43;
  logic         core_clk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  vip_apb_req_t apb_req = '0;
  logic         pready, pslverr, irq_req, pc_load, ack, mem_ready;
  logic         instr_done = 1'b0;
  logic         slow = 1'b0;
  logic [31:0]  prdata;
  logic [NS-1:0] src_req = '0;
  logic [23:0]  ret_pc = '0;
  logic [23:0]  new_pc;
  vip_mem_req_t mem;
  logic [7:0]   mem_rdata;
  int           bad_count = 0;
  int           samples_checked = 0;
  always #50 core_clk_i = ~core_clk_i;
  vip_top #(.NUM_SRC(NS)) vip_top_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .apb_i(apb_req), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .src_req_i(src_req), .instr_done_i(instr_done), .ret_pc_i(ret_pc), .irq_req_o(irq_req),
    .mem_o(mem), .mem_ready_i(mem_ready), .mem_rdata_i(mem_rdata), .pc_load_o(pc_load),
    .new_pc_o(new_pc), .ack_o(ack));
  vip_core_mem vip_core_mem_inst (.clk_i(core_clk_i), .mem_i(mem), .slow_i(slow),
    .ready_o(mem_ready), .rdata_o(mem_rdata));
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after an edge; holds the request until ready is sampled
  task automatic apb_do(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
    int n;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk_i);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      complete_run;
    end
    r = prdata;
    e = pslverr;
    apb_req <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb_do(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb_do(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(32'(e), 32'(experr));
  endtask
  function automatic logic [31:0] exp_status(input logic [NS-1:0] s);
    logic [7:0] v;
    v = 8'h00;
    for (int i = NS - 1; i >= 0; i--) if (s[i]) v = 8'(2 * i);
    return {22'h0, 1'b0, |s, v};
  endfunction
  initial begin
    logic [31:0]   r;
    logic          e, long_address_mode, mixed_mode_flag;
    logic [7:0]    vp, mb;
    logic [15:0]   short_stack_pointer;
    logic [23:0]   long_stack_pointer, pc, tv, tbl, sp;
    logic [NS-1:0] s;
    int            k, n, np, na;
    void'($urandom(32'hf4ad));
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    rchk(OFS_CTRL, 32'h0, 1'b0);
    rchk(OFS_SPS, 32'(SPS_RST), 1'b0);
    rchk(OFS_SPL, 32'(SPL_RST), 1'b0);
    rchk(8'h1C, 32'h0, 1'b1);
    // Corner patterns first, then sparse random ones at random depth
    for (int t = 0; t < 60; t++) begin
      s = t == 0 ? NS'(1) << (NS - 1) : t == 1 ? '0 : t == 2 ? '1 :
          NS'({$urandom, $urandom} & {$urandom, $urandom}) << $urandom_range(NS - 1, 0);
      src_req <= s;
      instr_done <= 1'($urandom);
      ret_pc <= 24'($urandom);
      repeat (2) @(posedge core_clk_i);
      chk(32'(irq_req), 32'(|s));
      apb_do(1'b0, OFS_STATUS, 32'h0, r, e);
      chk(r, exp_status(s));
    end
    for (int m = 0; m < 4; m++) begin
      long_address_mode = m[0];
      mixed_mode_flag = m[1];
      k = $urandom_range(NS - 1, 0);
      {vp, mb, short_stack_pointer} = 32'($urandom);
      long_stack_pointer = 24'($urandom);
      pc = 24'($urandom);
      tv = 24'($urandom);
      src_req <= '0;
      instr_done <= 1'b0;
      slow <= mixed_mode_flag;
      wr(OFS_VPAGE, 32'(vp));
      wr(OFS_MEM_PAGE_BASE, 32'(mb));
      wr(OFS_SPS, 32'(short_stack_pointer));
      wr(OFS_SPL, 32'(long_stack_pointer));
      tbl = {long_address_mode | mixed_mode_flag ? 8'h00 : mb, vp, 8'(2 * k)};
      for (int i = 0; i < 3; i++) vip_core_mem_inst.store[tbl + 24'(i)] = tv[8*i +: 8];
      wr(OFS_CTRL, {28'h0, mixed_mode_flag, long_address_mode, 2'b11});
      // Sources stay up until the service PC is loaded
      src_req <= NS'({$urandom, $urandom}) << k | NS'(1) << k;
      ret_pc <= pc;
      // No acknowledge until the core reaches an instruction boundary
      repeat (3) @(posedge core_clk_i);
      chk(32'(mem.req), 32'h0);
      instr_done <= 1'b1;
      n = 0;
      na = 0;
      while (pc_load !== 1'b1 && n < 80) begin
        @(posedge core_clk_i);
        na += int'(ack === 1'b1);
        n++;
      end
      if (pc_load !== 1'b1) begin
        chk(32'h0, 32'h1);
        complete_run;
      end
      chk(32'(na), 32'h1);
      chk(32'(new_pc), 32'(m == 0 ? {mb, tv[15:0]} : tv));
      np = long_address_mode ? 3 : 2;
      for (int i = 0; i < np; i++) begin
        sp = m == 0 ? {mb, short_stack_pointer - 16'(i + 1)} : long_stack_pointer - 24'(i + 1);
        chk(32'(vip_core_mem_inst.rd(sp)), 32'(pc[8*(np-1-i) +: 8]));
      end
      if (mixed_mode_flag) chk(32'(vip_core_mem_inst.rd(long_stack_pointer - 24'(np + 1))), long_address_mode ? 32'h03 : 32'h02);
      rchk(OFS_STATUS, {22'h0, 2'b01, 8'(2 * k)}, 1'b0);
      rchk(OFS_CTRL, mixed_mode_flag | long_address_mode ? {28'h0, mixed_mode_flag, 3'b100} : 32'h0, 1'b0);
      rchk(m == 0 ? OFS_SPS : OFS_SPL, m == 0 ? 32'(short_stack_pointer - 16'd2) :
           32'(long_stack_pointer - 24'(np + int'(mixed_mode_flag))), 1'b0);
    end
    // Reset in the middle of a stalled acknowledge
    wr(OFS_CTRL, 32'h3);
    src_req <= NS'(1);
    instr_done <= 1'b1;
    slow <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    src_req <= '0;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    chk(32'(mem.req), 32'h0);
    rchk(OFS_SPS, 32'(SPS_RST), 1'b0);
    rchk(OFS_CTRL, 32'h0, 1'b0);
    complete_run;
  end
endmodule
bind vip_top vip_sva #(.NUM_SRC(NUM_SRC)) vip_sva_inst (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .src_req_i(src_req_i), .instr_done_i(instr_done_i), .ret_pc_i(ret_pc_i),
  .irq_req_o(irq_req_o), .mem_o(mem_o), .mem_ready_i(mem_ready_i), .pc_load_o(pc_load_o),
  .ack_o(ack_o));

// [testbench/vip_core_mem.sv]
// Byte memory on the core side, answering promptly or with stalls
`timescale 1ns/10ps
module vip_core_mem (
  input  wire logic                  clk_i,
  input  wire vip_pkg::vip_mem_req_t mem_i,
  input  wire logic                  slow_i,
  output logic                       ready_o,
  output logic [7:0]                 rdata_o
);
  logic [7:0] store [logic [23:0]];
  logic [7:0] last_q = 8'h00;
  function automatic logic [7:0] rd(input logic [23:0] a);
    return store.exists(a) ? store[a] : 8'h00;
  endfunction
  initial ready_o = 1'b0;
  always @(posedge clk_i) begin
    if (mem_i.req && ready_o) begin
      if (mem_i.we) store[mem_i.addr] = mem_i.wdata;
      else last_q <= rd(mem_i.addr);
    end
    ready_o <= slow_i ? 1'($urandom_range(1, 0)) : 1'b1;
  end
  // Stale data is inverted so a late sample never looks right
  assign rdata_o = (mem_i.req && ready_o) ? rd(mem_i.addr) : ~last_q;
endmodule

// [testbench/vip_sva.sv]
// Port assertions for the vectored interrupt priority unit
`timescale 1ns/10ps
module vip_sva #(
  parameter int unsigned NUM_SRC = 43
) (
  input wire logic                  core_clk_i,
  input wire logic                  reset_n_i,
  input wire vip_pkg::vip_apb_req_t apb_i,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic [NUM_SRC-1:0]    src_req_i,
  input wire logic                  instr_done_i,
  input wire logic [23:0]           ret_pc_i,
  input wire logic                  irq_req_o,
  input wire vip_pkg::vip_mem_req_t mem_o,
  input wire logic                  mem_ready_i,
  input wire logic                  pc_load_o,
  input wire logic                  ack_o
);
  import vip_pkg::*;
  logic [23:0] pc_q;
  logic        acc_q;
  always_ff @(posedge core_clk_i) begin
    pc_q  <= ret_pc_i;
    acc_q <= apb_i.psel & apb_i.penable;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_irq_follows: assert property (
    $past(reset_n_i) |-> irq_req_o == $past(|src_req_i)) else $error("irq not tracking");
  a_ack_cause: assert property (
    ack_o |-> $past(irq_req_o) && $past(instr_done_i)) else $error("ack without cause");
  a_ack_once: assert property (
    ack_o |=> !ack_o [*5]) else $error("ack repeated");
  a_push_first: assert property (
    ack_o |-> mem_o.req && mem_o.we && (mem_o.wdata == pc_q[15:8] || mem_o.wdata == pc_q[23:16]))
    else $error("first push wrong");
  a_mem_hold: assert property (
    mem_o.req && !mem_ready_i |=> mem_o.req && $stable(mem_o)) else $error("request dropped");
  a_load_gap: assert property (
    pc_load_o |-> !mem_o.req && $past(mem_o.req, 2)) else $error("load not after read");
  a_pready_pulse: assert property (
    pready_o |-> acc_q ##1 !pready_o) else $error("bad ready");
  a_err_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
endmodule

// [verilog/vip_pkg.sv]
// Package for the vectored interrupt priority unit
// Notes on behaviour
// - Lowest vector wins; 00h is highest
// - Fixed even vectors, sources in listed order
// - Any active source raises the core request
// - Winning 8-bit vector driven on vector bus
// - Vector bus never leaves the device
// - Page byte and vector appear on address
// - Only the vectored response is supported
// - Take interrupt only at instruction boundary
// - Acknowledge reads vector, clears both enables
// - Mode 00 pushes 2 bytes, short stack
// - Mode 00 loads 16-bit counter from table
// - Mode 10 pushes 3 bytes, 24-bit vector
// - Mode 01 pushes 2 bytes, marker 02h
// - Mode 11 pushes 3 bytes, marker 03h
package vip_pkg;

  localparam int unsigned NUM_SRC_DEF = 43;
  localparam int unsigned VEC_SLOTS   = 48;
  localparam logic [7:0]  VEC_STEP    = 8'h02;
  localparam logic [7:0]  MARK_SHORT  = 8'h02;
  localparam logic [7:0]  MARK_LONG   = 8'h03;
  localparam logic [7:0]  PAGE_ZERO   = 8'h00;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_VPAGE  = 8'h04;
  localparam logic [7:0] OFS_MEM_PAGE_BASE  = 8'h08;
  localparam logic [7:0] OFS_SPS    = 8'h0C;
  localparam logic [7:0] OFS_SPL    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PC     = 8'h18;

  localparam int unsigned CTRL_IRQ_ENABLE_FLAG_ONE = 0;
  localparam int unsigned CTRL_IRQ_ENABLE_FLAG_TWO = 1;
  localparam int unsigned CTRL_ADL  = 2;
  localparam int unsigned CTRL_MIXED_MODE_FLAG = 3;
  localparam int unsigned STAT_IRQ  = 8;
  localparam int unsigned STAT_BUSY = 9;

  localparam logic [3:0]  CTRL_RST  = 4'h0;
  localparam logic [7:0]  VPAGE_RST = 8'h00;
  localparam logic [7:0]  MEM_PAGE_BASE_RST = 8'h00;
  localparam logic [15:0] SPS_RST   = 16'hFFFF;
  localparam logic [23:0] SPL_RST   = 24'hFF_FFFF;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } vip_apb_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } vip_mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_MARK = 3'b010,
    ST_READ = 3'b011,
    ST_LOAD = 3'b100
  } vip_state_t;

  function automatic logic [7:0] vip_byte(input logic [23:0] w, input logic [1:0] idx);
    vip_byte = w[8*idx +: 8];
  endfunction

endpackage

// [verilog/vip_prio_enc.sv]
// Fixed-priority encoder from source requests to an even vector
`timescale 1ns/10ps
module vip_prio_enc #(
  parameter int unsigned NUM_SRC = 43
) (
  input  wire logic [NUM_SRC-1:0] req_i,
  output logic                    any_o,
  output logic [7:0]              vector_o
);
  import vip_pkg::*;

  if (NUM_SRC < 1 || NUM_SRC > VEC_SLOTS) begin : g_bad_size
    $error("vip_prio_enc: NUM_SRC out of range");
  end

  always_comb begin
    any_o    = 1'b0;
    vector_o = 8'h00;
    // Scan downward so the lowest index is assigned last and wins
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o    = 1'b1;
        vector_o = 8'(i) * VEC_STEP;
      end
    end
  end
endmodule

// [verilog/vip_top.sv]
// Vectored interrupt priority unit with acknowledge sequencer and APB registers
`timescale 1ns/10ps
module vip_top #(
  parameter int unsigned NUM_SRC = vip_pkg::NUM_SRC_DEF
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire vip_pkg::vip_apb_req_t apb_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  input  wire logic [NUM_SRC-1:0]    src_req_i,
  input  wire logic                  instr_done_i,
  input  wire logic [23:0]           ret_pc_i,
  output logic                       irq_req_o,
  output vip_pkg::vip_mem_req_t      mem_o,
  input  wire logic                  mem_ready_i,
  input  wire logic [7:0]            mem_rdata_i,
  output logic                       pc_load_o,
  output logic [23:0]                new_pc_o,
  output logic                       ack_o
);
  import vip_pkg::*;

  if (NUM_SRC < 1 || NUM_SRC > VEC_SLOTS) begin : g_bad_size
    $error("vip_top: NUM_SRC out of range");
  end

  logic       enc_any;
  logic [7:0] enc_vector;

  vip_prio_enc #(
    .NUM_SRC (NUM_SRC)
  ) u_enc (
    .req_i    (src_req_i),
    .any_o    (enc_any),
    .vector_o (enc_vector)
  );

  // Source tracking; no latching, sources must hold until service starts
  logic       irq_req_reg;
  logic       irq_req_next;
  logic [7:0] irq_vector_bus_reg;
  logic [7:0] irq_vector_bus_next;

  always_comb begin
    irq_req_next        = enc_any;
    irq_vector_bus_next = enc_vector;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_req_reg        <= 1'b0;
      irq_vector_bus_reg <= 8'h00;
    end else begin
      irq_req_reg        <= irq_req_next;
      irq_vector_bus_reg <= irq_vector_bus_next;
    end
  end

  // Software state and acknowledge sequencer
  vip_state_t   state_reg;
  vip_state_t   state_next;
  logic [1:0]   cnt_reg;
  logic [1:0]   cnt_next;
  logic [1:0]   mode_reg;
  logic [1:0]   mode_next;
  logic [7:0]   vec_reg;
  logic [7:0]   vec_next;
  logic [23:0]  pc_hold_reg;
  logic [23:0]  pc_hold_next;
  logic [23:0]  work_sp_reg;
  logic [23:0]  work_sp_next;
  logic         irq_enable_flag_one_reg;
  logic         irq_enable_flag_one_next;
  logic         irq_enable_flag_two_reg;
  logic         irq_enable_flag_two_next;
  logic         long_address_mode_reg;
  logic         long_address_mode_next;
  logic         mixed_mode_flag_reg;
  logic         mixed_mode_flag_next;
  logic [7:0]   vec_page_reg;
  logic [7:0]   vec_page_next;
  logic [7:0]   mem_page_base_reg;
  logic [7:0]   mem_page_base_next;
  logic [15:0]  short_stack_pointer_reg;
  logic [15:0]  short_stack_pointer_next;
  logic [23:0]  long_stack_pointer_reg;
  logic [23:0]  long_stack_pointer_next;
  logic [23:0]  last_pc_reg;
  logic [23:0]  last_pc_next;
  vip_mem_req_t mem_reg;
  vip_mem_req_t mem_next;
  logic         pc_load_reg;
  logic         pc_load_next;
  logic         ack_reg;
  logic         ack_next;
  logic         pready_reg;
  logic         pready_next;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pslverr_reg;
  logic         pslverr_next;

  logic         apb_wr;
  logic         apb_access;
  logic         mapped;
  logic [31:0]  rd_word;
  logic [23:0]  table_base;

  always_comb begin
    apb_access = apb_i.psel && apb_i.penable;
    apb_wr     = apb_access && pready_reg && apb_i.pwrite;
    mapped     = 1'b1;
    rd_word    = 32'h0000_0000;
    unique case (apb_i.paddr)
      OFS_CTRL: begin
        rd_word[CTRL_IRQ_ENABLE_FLAG_ONE] = irq_enable_flag_one_reg;
        rd_word[CTRL_IRQ_ENABLE_FLAG_TWO] = irq_enable_flag_two_reg;
        rd_word[CTRL_ADL]  = long_address_mode_reg;
        rd_word[CTRL_MIXED_MODE_FLAG] = mixed_mode_flag_reg;
      end
      OFS_VPAGE:  rd_word[7:0]  = vec_page_reg;
      OFS_MEM_PAGE_BASE:  rd_word[7:0]  = mem_page_base_reg;
      OFS_SPS:    rd_word[15:0] = short_stack_pointer_reg;
      OFS_SPL:    rd_word[23:0] = long_stack_pointer_reg;
      OFS_STATUS: begin
        // Vector bus is readable here only; it has no pin of its own
        rd_word[7:0]     = irq_vector_bus_reg;
        rd_word[STAT_IRQ]  = irq_req_reg;
        rd_word[STAT_BUSY] = (state_reg != ST_IDLE);
      end
      OFS_PC:     rd_word[23:0] = last_pc_reg;
      default:    mapped = 1'b0;
    endcase
  end

  // APB slave: one wait state, so pready and read data both come from flops
  always_comb begin
    pready_next  = apb_access && !pready_reg;
    prdata_next  = (apb_access && !pready_reg) ? rd_word : 32'h0000_0000;
    pslverr_next = apb_access && !pready_reg && !mapped;
  end

  always_comb begin
    state_next               = state_reg;
    cnt_next                 = cnt_reg;
    mode_next                = mode_reg;
    vec_next                 = vec_reg;
    pc_hold_next             = pc_hold_reg;
    work_sp_next             = work_sp_reg;
    irq_enable_flag_one_next = irq_enable_flag_one_reg;
    irq_enable_flag_two_next = irq_enable_flag_two_reg;
    long_address_mode_next   = long_address_mode_reg;
    mixed_mode_flag_next     = mixed_mode_flag_reg;
    vec_page_next            = vec_page_reg;
    mem_page_base_next       = mem_page_base_reg;
    short_stack_pointer_next = short_stack_pointer_reg;
    long_stack_pointer_next  = long_stack_pointer_reg;
    last_pc_next             = last_pc_reg;
    pc_load_next             = 1'b0;
    ack_next                 = 1'b0;
    table_base               = 24'h00_0000;

    // Software writes first; sequencer updates below override them
    if (apb_wr) begin
      unique case (apb_i.paddr)
        OFS_CTRL: begin
          irq_enable_flag_one_next = apb_i.pwdata[CTRL_IRQ_ENABLE_FLAG_ONE];
          irq_enable_flag_two_next = apb_i.pwdata[CTRL_IRQ_ENABLE_FLAG_TWO];
          long_address_mode_next   = apb_i.pwdata[CTRL_ADL];
          mixed_mode_flag_next     = apb_i.pwdata[CTRL_MIXED_MODE_FLAG];
        end
        OFS_VPAGE: vec_page_next            = apb_i.pwdata[7:0];
        OFS_MEM_PAGE_BASE: mem_page_base_next       = apb_i.pwdata[7:0];
        OFS_SPS:   short_stack_pointer_next = apb_i.pwdata[15:0];
        OFS_SPL:   long_stack_pointer_next  = apb_i.pwdata[23:0];
        default: ;
      endcase
    end

    unique case (state_reg)
      ST_IDLE: begin
        // Only the vectored response exists; no other mode is decoded
        if (irq_req_reg && irq_enable_flag_one_reg && instr_done_i) begin
          vec_next                 = irq_vector_bus_reg;
          irq_enable_flag_one_next = 1'b0;
          irq_enable_flag_two_next = 1'b0;
          mode_next                = {long_address_mode_reg, mixed_mode_flag_reg};
          pc_hold_next             = ret_pc_i;
          ack_next                 = 1'b1;
          cnt_next                 = long_address_mode_reg ? 2'd3 : 2'd2;
          if (!long_address_mode_reg && !mixed_mode_flag_reg) begin
            work_sp_next = {mem_page_base_reg, short_stack_pointer_reg};
          end else begin
            work_sp_next = long_stack_pointer_reg;
          end
          state_next = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (mem_ready_i) begin
          work_sp_next = work_sp_reg - 24'h00_0001;
          cnt_next     = cnt_reg - 2'd1;
          if (cnt_reg == 2'd1) begin
            state_next = mode_reg[0] ? ST_MARK : ST_READ;
            cnt_next   = (mode_reg == 2'b00) ? 2'd2 : 2'd3;
          end
        end
      end
      ST_MARK: begin
        if (mem_ready_i) begin
          work_sp_next = work_sp_reg - 24'h00_0001;
          state_next   = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_ready_i) begin
          // Table entry is little-endian, first byte read lands lowest
          pc_hold_next[8*cnt_next_idx(mode_reg, cnt_reg) +: 8] = mem_rdata_i;
          cnt_next = cnt_reg - 2'd1;
          if (cnt_reg == 2'd1) begin
            state_next = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        pc_load_next = 1'b1;
        if (mode_reg == 2'b00) begin
          last_pc_next             = {mem_page_base_reg, pc_hold_reg[15:0]};
          short_stack_pointer_next = work_sp_reg[15:0];
          long_address_mode_next   = 1'b0;
        end else begin
          last_pc_next            = pc_hold_reg;
          long_stack_pointer_next = work_sp_reg;
          long_address_mode_next  = 1'b1;
        end
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase

    // Bus request for the cycle to come, held stable until mem_ready_i
    mem_next = '0;
    if (mode_next == 2'b00) begin
      table_base = {mem_page_base_reg, vec_page_reg, vec_next};
    end else begin
      table_base = {PAGE_ZERO, vec_page_reg, vec_next};
    end
    unique case (state_next)
      ST_PUSH: begin
        mem_next.req   = 1'b1;
        mem_next.we    = 1'b1;
        mem_next.addr  = work_sp_next - 24'h00_0001;
        // High byte first so the low byte ends at the lowest address
        mem_next.wdata = vip_byte(pc_hold_next, cnt_next - 2'd1);
      end
      ST_MARK: begin
        mem_next.req   = 1'b1;
        mem_next.we    = 1'b1;
        mem_next.addr  = work_sp_next - 24'h00_0001;
        mem_next.wdata = mode_reg[1] ? MARK_LONG : MARK_SHORT;
      end
      ST_READ: begin
        mem_next.req  = 1'b1;
        mem_next.addr = table_base + {22'h00_0000, cnt_next_idx(mode_next, cnt_next)};
      end
      default: ;
    endcase
  end

  // Byte index within the table entry, counting up from zero
  function automatic logic [1:0] cnt_next_idx(input logic [1:0] mode, input logic [1:0] cnt);
    cnt_next_idx = ((mode == 2'b00) ? 2'd2 : 2'd3) - cnt;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_reg               <= ST_IDLE;
      cnt_reg                 <= 2'd0;
      mode_reg                <= 2'b00;
      vec_reg                 <= 8'h00;
      pc_hold_reg             <= 24'h00_0000;
      work_sp_reg             <= 24'h00_0000;
      irq_enable_flag_one_reg <= CTRL_RST[CTRL_IRQ_ENABLE_FLAG_ONE];
      irq_enable_flag_two_reg <= CTRL_RST[CTRL_IRQ_ENABLE_FLAG_TWO];
      long_address_mode_reg   <= CTRL_RST[CTRL_ADL];
      mixed_mode_flag_reg     <= CTRL_RST[CTRL_MIXED_MODE_FLAG];
      vec_page_reg            <= VPAGE_RST;
      mem_page_base_reg       <= MEM_PAGE_BASE_RST;
      short_stack_pointer_reg <= SPS_RST;
      long_stack_pointer_reg  <= SPL_RST;
      last_pc_reg             <= 24'h00_0000;
      mem_reg                 <= '0;
      pc_load_reg             <= 1'b0;
      ack_reg                 <= 1'b0;
      pready_reg              <= 1'b0;
      prdata_reg              <= 32'h0000_0000;
      pslverr_reg             <= 1'b0;
    end else begin
      state_reg               <= state_next;
      cnt_reg                 <= cnt_next;
      mode_reg                <= mode_next;
      vec_reg                 <= vec_next;
      pc_hold_reg             <= pc_hold_next;
      work_sp_reg             <= work_sp_next;
      irq_enable_flag_one_reg <= irq_enable_flag_one_next;
      irq_enable_flag_two_reg <= irq_enable_flag_two_next;
      long_address_mode_reg   <= long_address_mode_next;
      mixed_mode_flag_reg     <= mixed_mode_flag_next;
      vec_page_reg            <= vec_page_next;
      mem_page_base_reg       <= mem_page_base_next;
      short_stack_pointer_reg <= short_stack_pointer_next;
      long_stack_pointer_reg  <= long_stack_pointer_next;
      last_pc_reg             <= last_pc_next;
      mem_reg                 <= mem_next;
      pc_load_reg             <= pc_load_next;
      ack_reg                 <= ack_next;
      pready_reg              <= pready_next;
      prdata_reg              <= prdata_next;
      pslverr_reg             <= pslverr_next;
    end
  end

  always_comb begin
    irq_req_o = irq_req_reg;
    mem_o     = mem_reg;
    pc_load_o = pc_load_reg;
    new_pc_o  = last_pc_reg;
    ack_o     = ack_reg;
    pready_o  = pready_reg;
    prdata_o  = prdata_reg;
    pslverr_o = pslverr_reg;
  end
endmodule
